// file: include/t16w_regs.svh
/*
 * Register offsets, field positions, mode codes, reset values and divider counts
 * of the 16-bit waveform timer. Assumes a 3-bit word address and 16-bit data.
 */
`ifndef T16W_REGS_SVH
`define T16W_REGS_SVH

`define T16W_ADDR_CTRL 3'h0
`define T16W_ADDR_COUNT 3'h1
`define T16W_ADDR_CMP_A 3'h2
`define T16W_ADDR_CMP_B 3'h3
`define T16W_ADDR_CAPTURE 3'h4
`define T16W_ADDR_FLAGS 3'h5
`define T16W_ADDR_PIN 3'h6

`define T16W_CTRL_MODE_F 3:0
`define T16W_CTRL_CS_F 6:4
`define T16W_CTRL_ACT_A_F 9:8
`define T16W_CTRL_ACT_B_F 11:10

`define T16W_FLG_OVF 0
`define T16W_FLG_CMP_A 1
`define T16W_FLG_CMP_B 2
`define T16W_FLG_CAP 3
`define T16W_FLG_F 3:0

`define T16W_PIN_DIR_F 1:0
`define T16W_PIN_PORT_F 3:2

`define T16W_MODE_CTC_A 4'h4
`define T16W_MODE_PWM8 4'h5
`define T16W_MODE_PWM9 4'h6
`define T16W_MODE_PWM10 4'h7
`define T16W_MODE_CTC_CAP 4'hc
`define T16W_MODE_PWM_CAP 4'he
`define T16W_MODE_PWM_A 4'hf

`define T16W_TOP8 16'h00ff
`define T16W_TOP9 16'h01ff
`define T16W_TOP10 16'h03ff
`define T16W_MAX 16'hffff
`define T16W_BOTTOM 16'h0000

`define T16W_ACT_OFF 2'h0
`define T16W_ACT_TOGGLE 2'h1
`define T16W_ACT_CLEAR 2'h2
`define T16W_ACT_SET 2'h3

`define T16W_CS_STOP 3'h0
`define T16W_CS_1 3'h1
`define T16W_CS_8 3'h2
`define T16W_CS_64 3'h3
`define T16W_CS_256 3'h4
`define T16W_CS_1024 3'h5
`define T16W_DIV8_LAST 10'h007
`define T16W_DIV64_LAST 10'h03f
`define T16W_DIV256_LAST 10'h0ff
`define T16W_DIV1024_LAST 10'h3ff

`define T16W_RST_16 16'h0000
`define T16W_RST_4 4'h0
`define T16W_RST_2 2'h0
`define T16W_RST_OEN 2'h3

`endif

// file: include/t16w_pkg.sv
/*
 * Types of the 16-bit waveform timer: control word, pin control and flags.
 * Assumes t16w_regs.svh for the field positions; the pin and flag types mirror them, the control type has no gap at bit 7.
 */
package t16w_pkg;

	typedef struct packed {
		logic [1:0] act_b;
		logic [1:0] act_a;
		logic [2:0] clk_sel;
		logic [3:0] mode;
	} t16w_ctrl_t;

	typedef struct packed {
		logic [1:0] port;
		logic [1:0] dir;
	} t16w_pin_t;

	typedef struct packed {
		logic cap;
		logic cmp_b;
		logic cmp_a;
		logic ovf;
	} t16w_flags_t;

endpackage

// file: hdl/t16w_prescale.sv
/*
 * Prescaler: turns the I/O clock into timer ticks of 1, 8, 64, 256 or 1024 cycles.
 * Assumes clk_sel_i comes from a register on the same clock.
 */
`timescale 1ns/1ps
`include "t16w_regs.svh"

module t16w_prescale #(
	parameter int DIV_W = 10
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [2:0] clk_sel_i,
	output logic tick_o
);

	if (DIV_W < 10) begin : g_chk
		$error("t16w_prescale: DIV_W must cover the 1024 divider");
	end

	logic [DIV_W-1:0] div_q;
	logic [9:0] last;

	// Stopped prescaler restarts from zero so the first tick after start is a full period
	always_ff @(posedge clk_i) begin
		if (!rstn_i || clk_sel_i == `T16W_CS_STOP) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	always_comb begin
		last = `T16W_DIV1024_LAST;
		tick_o = 1'b0;
		case (clk_sel_i)
			`T16W_CS_STOP: tick_o = 1'b0;
			`T16W_CS_1: tick_o = 1'b1;
			`T16W_CS_8: last = `T16W_DIV8_LAST;
			`T16W_CS_64: last = `T16W_DIV64_LAST;
			`T16W_CS_256: last = `T16W_DIV256_LAST;
			default: last = `T16W_DIV1024_LAST;
		endcase
		if (clk_sel_i != `T16W_CS_STOP && clk_sel_i != `T16W_CS_1) begin
			tick_o = ((div_q[9:0] & last) == last);
		end
	end

endmodule

// file: hdl/t16w_chan.sv
/*
 * One compare register with its buffer. Writes are masked to the active
 * resolution; in buffered modes the active value follows the buffer at top.
 * Assumes load_i is a single-cycle strobe on the same clock.
 */
`timescale 1ns/1ps
`include "t16w_regs.svh"

module t16w_chan #(
	parameter int W = 16
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic wr_i,
	input wire logic [W-1:0] wdata_i,
	input wire logic [W-1:0] mask_i,
	input wire logic buffered_i,
	input wire logic load_i,
	output logic [W-1:0] buf_o,
	output logic [W-1:0] active_o
);

	if (W < 2) begin : g_chk
		$error("t16w_chan: W too small");
	end

	logic [W-1:0] buf_q;
	logic [W-1:0] active_q;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			buf_q <= '0;
		end else if (wr_i) begin
			buf_q <= wdata_i & mask_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			active_q <= '0;
		end else if (wr_i && !buffered_i) begin
			active_q <= wdata_i & mask_i;
		end else if (buffered_i && load_i) begin
			active_q <= buf_q;
		end
	end

	assign buf_o = buf_q;
	assign active_o = active_q;

	AST_BUF_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		buffered_i && !load_i |=> active_o == $past(active_o))
		else $error("compare value changed outside top in buffered mode");

endmodule

// file: hdl/t16w_top.sv
/*
 * 16-bit timer with clear-on-match and single-slope PWM waveform generation,
 * two compare channels, sticky flags and pin override.
 * Assumes a simple register port on clk_i; pin buffers live outside.
 */
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "t16w_regs.svh"

module t16w_top #(
	parameter int W = 16,
	parameter int DIV_W = 10
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [2:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [15:0] rdata_o,
	output logic [1:0] wave_pin_o,
	output logic [1:0] wave_pin_oen_o
);

	if (W != 16) begin : g_chk
		$error("t16w_top: counter width must be 16");
	end

	t16w_pkg::t16w_ctrl_t ctrl_q;
	t16w_pkg::t16w_pin_t pin_q;
	t16w_pkg::t16w_flags_t flags_q;
	t16w_pkg::t16w_flags_t flags_set;
	t16w_pkg::t16w_flags_t flags_clr;
	logic [15:0] count_q;
	logic [15:0] cap_q;
	logic [15:0] rdata_q;
	logic [1:0] wave_q;
	logic [1:0] pin_out_q;
	logic [1:0] pin_oen_q;

	logic tick;
	logic is_ctc;
	logic is_pwm;
	logic top_is_cap;
	logic [15:0] top_w;
	logic [15:0] cmp_mask;
	logic at_top;
	logic bottom;
	logic match_a;
	logic match_b;
	logic cnt_wr;
	logic cmp_a_wr;
	logic cmp_b_wr;
	logic [15:0] cmp_a_buf;
	logic [15:0] cmp_a_act;
	logic [15:0] cmp_b_buf;
	logic [15:0] cmp_b_act;
	logic [1:0] wave_d;
	logic [1:0] ovr;

	// Register port
	assign cnt_wr = we_i && addr_i == `T16W_ADDR_COUNT;
	assign cmp_a_wr = we_i && addr_i == `T16W_ADDR_CMP_A;
	assign cmp_b_wr = we_i && addr_i == `T16W_ADDR_CMP_B;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ctrl_q <= '0;
		end else if (we_i && addr_i == `T16W_ADDR_CTRL) begin
			ctrl_q.mode <= wdata_i[`T16W_CTRL_MODE_F];
			ctrl_q.clk_sel <= wdata_i[`T16W_CTRL_CS_F];
			ctrl_q.act_a <= wdata_i[`T16W_CTRL_ACT_A_F];
			ctrl_q.act_b <= wdata_i[`T16W_CTRL_ACT_B_F];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pin_q <= '0;
		end else if (we_i && addr_i == `T16W_ADDR_PIN) begin
			pin_q.dir <= wdata_i[`T16W_PIN_DIR_F];
			pin_q.port <= wdata_i[`T16W_PIN_PORT_F];
		end
	end

	// Capture top has no buffer: a write lands at once
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cap_q <= `T16W_RST_16;
		end else if (we_i && addr_i == `T16W_ADDR_CAPTURE) begin
			cap_q <= wdata_i;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!rstn_i || !re_i) begin
			rdata_q <= `T16W_RST_16;
		end else begin
			case (addr_i)
				`T16W_ADDR_CTRL: rdata_q <= {4'h0, ctrl_q.act_b, ctrl_q.act_a, 1'b0, ctrl_q.clk_sel, ctrl_q.mode};
				`T16W_ADDR_COUNT: rdata_q <= count_q;
				`T16W_ADDR_CMP_A: rdata_q <= cmp_a_buf;
				`T16W_ADDR_CMP_B: rdata_q <= cmp_b_buf;
				`T16W_ADDR_CAPTURE: rdata_q <= cap_q;
				`T16W_ADDR_FLAGS: rdata_q <= {12'h000, flags_q};
				`T16W_ADDR_PIN: rdata_q <= {10'h000, wave_q, pin_q.port, pin_q.dir};
				default: rdata_q <= `T16W_RST_16;
			endcase
		end
	end

	assign rdata_o = rdata_q;

	// Mode decode
	always_comb begin
		is_ctc = 1'b0;
		is_pwm = 1'b0;
		top_is_cap = 1'b0;
		top_w = `T16W_MAX;
		cmp_mask = `T16W_MAX;
		case (ctrl_q.mode)
			`T16W_MODE_CTC_A: begin
				is_ctc = 1'b1;
				top_w = cmp_a_act;
			end
			`T16W_MODE_CTC_CAP: begin
				is_ctc = 1'b1;
				top_is_cap = 1'b1;
				top_w = cap_q;
			end
			`T16W_MODE_PWM8: begin
				is_pwm = 1'b1;
				top_w = `T16W_TOP8;
				cmp_mask = `T16W_TOP8;
			end
			`T16W_MODE_PWM9: begin
				is_pwm = 1'b1;
				top_w = `T16W_TOP9;
				cmp_mask = `T16W_TOP9;
			end
			`T16W_MODE_PWM10: begin
				is_pwm = 1'b1;
				top_w = `T16W_TOP10;
				cmp_mask = `T16W_TOP10;
			end
			`T16W_MODE_PWM_CAP: begin
				is_pwm = 1'b1;
				top_is_cap = 1'b1;
				top_w = cap_q;
			end
			`T16W_MODE_PWM_A: begin
				is_pwm = 1'b1;
				top_w = cmp_a_act;
			end
			default: top_w = `T16W_MAX;
		endcase
	end

	t16w_prescale #(
		.DIV_W(DIV_W)
	) u_prescale (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.clk_sel_i(ctrl_q.clk_sel),
		.tick_o(tick)
	);

	t16w_chan #(
		.W(W)
	) u_chan_a (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.wr_i(cmp_a_wr),
		.wdata_i(wdata_i),
		.mask_i(cmp_mask),
		.buffered_i(is_pwm),
		.load_i(bottom),
		.buf_o(cmp_a_buf),
		.active_o(cmp_a_act)
	);

	t16w_chan #(
		.W(W)
	) u_chan_b (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.wr_i(cmp_b_wr),
		.wdata_i(wdata_i),
		.mask_i(cmp_mask),
		.buffered_i(is_pwm),
		.load_i(bottom),
		.buf_o(cmp_b_buf),
		.active_o(cmp_b_act)
	);

	// Equality only: a top written below the count is missed until the wrap
	assign at_top = (is_ctc || is_pwm) && count_q == top_w;
	assign bottom = tick && at_top;
	assign match_a = count_q == cmp_a_act;
	assign match_b = count_q == cmp_b_act;

	// A software count write beats a tick in the same cycle
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			count_q <= `T16W_BOTTOM;
		end else if (cnt_wr) begin
			count_q <= wdata_i;
		end else if (tick) begin
			if (at_top) begin
				count_q <= `T16W_BOTTOM;
			end else begin
				count_q <= count_q + 16'h0001;
			end
		end
	end

	// Flags: hardware set wins over a write-one clear in the same cycle
	always_comb begin
		flags_set = '0;
		flags_set.ovf = tick && (is_pwm ? at_top : count_q == `T16W_MAX);
		flags_set.cmp_a = tick && match_a;
		flags_set.cmp_b = tick && match_b;
		flags_set.cap = bottom && top_is_cap;
		flags_clr = '0;
		if (we_i && addr_i == `T16W_ADDR_FLAGS) begin
			flags_clr = wdata_i[`T16W_FLG_F];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			flags_q <= '0;
		end else begin
			flags_q <= (flags_q & ~flags_clr) | flags_set;
		end
	end

	// Next waveform state; in PWM clear and set, bottom wins over a match on the same tick so that
	// a compare equal to top gives a steady level instead of a glitch
	function automatic logic wave_next(input logic cur, input logic [1:0] act, input logic hit,
		input logic bot, input logic clear_on_match_mode, input logic pwm, input logic may_toggle);
		logic n;
		n = cur;
		if (clear_on_match_mode) begin
			case (act)
				`T16W_ACT_TOGGLE: n = hit ? ~cur : cur;
				`T16W_ACT_CLEAR: n = hit ? 1'b0 : cur;
				`T16W_ACT_SET: n = hit ? 1'b1 : cur;
				default: n = cur;
			endcase
		end else if (pwm) begin
			case (act)
				`T16W_ACT_TOGGLE: n = (may_toggle && hit) ? ~cur : cur;
				`T16W_ACT_CLEAR: n = bot ? 1'b1 : (hit ? 1'b0 : cur);
				`T16W_ACT_SET: n = bot ? 1'b0 : (hit ? 1'b1 : cur);
				default: n = cur;
			endcase
		end
		return n;
	endfunction

	always_comb begin
		wave_d[0] = wave_next(wave_q[0], ctrl_q.act_a, tick && match_a, bottom, is_ctc, is_pwm,
			ctrl_q.mode == `T16W_MODE_PWM_A);
		wave_d[1] = wave_next(wave_q[1], ctrl_q.act_b, tick && match_b, bottom, is_ctc, is_pwm, 1'b0);
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wave_q <= `T16W_RST_2;
		end else begin
			wave_q <= wave_d;
		end
	end

	// Toggle in PWM has no effect on the pin except for channel A in mode 15
	always_comb begin
		ovr[0] = ctrl_q.act_a != `T16W_ACT_OFF &&
			!(is_pwm && ctrl_q.act_a == `T16W_ACT_TOGGLE && ctrl_q.mode != `T16W_MODE_PWM_A);
		ovr[1] = ctrl_q.act_b != `T16W_ACT_OFF && !(is_pwm && ctrl_q.act_b == `T16W_ACT_TOGGLE);
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pin_out_q <= `T16W_RST_2;
			pin_oen_q <= `T16W_RST_OEN;
		end else begin
			for (int i = 0; i < 2; i++) begin
				pin_out_q[i] <= ovr[i] ? wave_q[i] : pin_q.port[i];
				pin_oen_q[i] <= ~pin_q.dir[i];
			end
		end
	end

	assign wave_pin_o = pin_out_q;
	assign wave_pin_oen_o = pin_oen_q;

	AST_CTC_CLEAR: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tick && is_ctc && count_q == top_w && !cnt_wr |=> count_q == 16'h0000)
		else $error("counter not cleared after top match");

	AST_CTC_TOP_FLAG: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tick && ctrl_q.mode == `T16W_MODE_CTC_CAP && count_q == cap_q |=> flags_q.cap)
		else $error("capture flag missing at top");

	AST_CTC_WRAP: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tick && is_ctc && count_q > top_w && count_q != 16'hffff && !cnt_wr
		|=> count_q == 16'($past(count_q) + 16'h0001))
		else $error("counter did not run on past a missed top");

	AST_CTC_TOGGLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tick && is_ctc && ctrl_q.act_a == `T16W_ACT_TOGGLE && match_a |=> wave_q[0] != $past(wave_q[0]))
		else $error("output A did not toggle on match");

	AST_PIN_RELEASE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!pin_q.dir[0] ##1 !pin_q.dir[0] |-> wave_pin_oen_o[0])
		else $error("pin A driven while direction is input");

	AST_CTC_OVF: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tick && is_ctc && count_q == 16'hffff |=> flags_q.ovf && count_q == 16'h0000 || $past(cnt_wr))
		else $error("overflow flag missing at rollover");

	AST_PWM_TOP: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tick && is_pwm && count_q == top_w && !cnt_wr |=> count_q == 16'h0000 && flags_q.ovf)
		else $error("PWM counter not cleared at top");

	AST_PWM_NONINV: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tick && is_pwm && ctrl_q.act_a == `T16W_ACT_CLEAR && match_a && !at_top |=> !wave_q[0])
		else $error("non-inverted output not cleared on match");

	AST_PWM_BOTTOM: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tick && is_pwm && ctrl_q.act_b == `T16W_ACT_SET && at_top |=> !wave_q[1])
		else $error("inverted output not cleared at bottom");

	AST_PWM_CMP_FLAG: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tick && is_pwm && match_b |=> flags_q.cmp_b)
		else $error("compare B flag missing");

	AST_PWM_LOAD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tick && is_pwm && at_top |=> cmp_a_act == $past(cmp_a_buf))
		else $error("compare A not loaded from buffer at top");

endmodule

// file: verif/tb.sv
/*
 * Self-checking bench for the 16-bit waveform timer: register access, pin control,
 * clear-on-match and single-slope PWM timing. Assumes t16w_top and t16w_regs.svh.
 */
`timescale 1ns/1ps
`include "t16w_regs.svh"

module tb;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [2:0] addr_i = 3'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic we_i = 1'b0;
	logic re_i = 1'b0;
	logic [15:0] rdata_o;
	logic [1:0] wave_pin_o;
	logic [1:0] wave_pin_oen_o;
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;
	int dv [5] = '{1, 8, 64, 256, 1024};

	t16w_top u_t16w_top (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.we_i(we_i),
		.re_i(re_i),
		.rdata_o(rdata_o),
		.wave_pin_o(wave_pin_o),
		.wave_pin_oen_o(wave_pin_oen_o)
	);

	always #12.5 clk_i = ~clk_i;

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Long enough for the slowest prescaler measurement with margin
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_i);
		we_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clk_i);
		re_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1;
		chk("read data", e, rdata_o & m);
	endtask

	// Counter restart keeps a mode switch from landing above the new top
	task automatic set_mode(input logic [15:0] c);
		wr(`T16W_ADDR_CTRL, c);
		wr(`T16W_ADDR_COUNT, 16'h0000);
	endtask

	task automatic step();
		@(posedge clk_i);
		#1;
	endtask

	task automatic meas(input int b, input int hi, input int lo);
		int n;
		int h;
		int l;
		n = 0;
		h = 0;
		l = 0;
		while (wave_pin_o[b] !== 1'b0 && n < 10000) begin
			step();
			n++;
		end
		while (wave_pin_o[b] !== 1'b1 && n < 10000) begin
			step();
			n++;
		end
		while (wave_pin_o[b] === 1'b1 && h < 10000) begin
			step();
			h++;
		end
		while (wave_pin_o[b] === 1'b0 && l < 10000) begin
			step();
			l++;
		end
		chk("pin high time", 16'(hi), 16'(h));
		chk("pin low time", 16'(lo), 16'(l));
	endtask

	initial begin
		int bad;
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		for (int a = 0; a < 8; a++) rd(3'(a), 16'hffff, 16'h0000);
		chk("pin enable", 16'h0003, {14'h0, wave_pin_oen_o});
		wr(`T16W_ADDR_PIN, 16'h0004);
		repeat (2) step();
		chk("port value", 16'h0001, {15'h0, wave_pin_o[0]});
		chk("pin enable", 16'h0003, {14'h0, wave_pin_oen_o});
		wr(`T16W_ADDR_PIN, 16'h0007);
		repeat (2) step();
		chk("pin enable", 16'h0000, {14'h0, wave_pin_oen_o});
		wr(`T16W_ADDR_CMP_A, 16'h0002);
		for (int s = 0; s < 5; s++) begin
			set_mode(16'h0104 | 16'((s + 1) << 4));
			meas(0, 3 * dv[s], 3 * dv[s]);
		end
		// Clear-on-match set and clear actions on channel B, compare B still zero
		set_mode(16'h0c14);
		repeat (6) step();
		chk("pin b set on match", 16'h0001, {15'h0, wave_pin_o[1]});
		rd(`T16W_ADDR_PIN, 16'h0020, 16'h0020);
		set_mode(16'h0814);
		repeat (6) step();
		rd(`T16W_ADDR_PIN, 16'h0020, 16'h0000);
		chk("pin b clear on match", 16'h0000, {15'h0, wave_pin_o[1]});
		set_mode(16'h0114);
		wr(`T16W_ADDR_COUNT, 16'hfff0);
		wr(`T16W_ADDR_FLAGS, 16'h000f);
		repeat (5) step();
		rd(`T16W_ADDR_FLAGS, 16'h0003, 16'h0000);
		repeat (20) step();
		rd(`T16W_ADDR_FLAGS, 16'h0003, 16'h0003);
		wr(`T16W_ADDR_CAPTURE, 16'h0004);
		set_mode(16'h001c);
		wr(`T16W_ADDR_FLAGS, 16'h000f);
		repeat (10) step();
		rd(`T16W_ADDR_FLAGS, 16'h0009, 16'h0008);
		wr(`T16W_ADDR_CMP_A, 16'h0003);
		set_mode(16'h011f);
		meas(0, 4, 4);
		wr(`T16W_ADDR_CAPTURE, 16'h0007);
		wr(`T16W_ADDR_CMP_A, 16'h0002);
		wr(`T16W_ADDR_CMP_B, 16'h0000);
		for (int act = 2; act < 4; act++) begin
			set_mode(16'h001e | 16'(act << 8) | 16'(act << 10));
			meas(0, act == 2 ? 3 : 5, act == 2 ? 5 : 3);
			meas(1, act == 2 ? 1 : 7, act == 2 ? 7 : 1);
		end
		wr(`T16W_ADDR_FLAGS, 16'h000f);
		repeat (12) step();
		rd(`T16W_ADDR_FLAGS, 16'h000f, 16'h000f);
		wr(`T16W_ADDR_CMP_B, 16'h0007);
		repeat (20) step();
		bad = 0;
		for (int i = 0; i < 16; i++) begin
			step();
			if (wave_pin_o[1] !== 1'b0) bad++;
		end
		chk("steady pin b", 16'h0000, 16'(bad));
		wr(`T16W_ADDR_CMP_A, 16'h0009);
		wr(`T16W_ADDR_CMP_B, 16'h0004);
		repeat (10) step();
		set_mode(16'h081f);
		meas(1, 5, 5);
		wr(`T16W_ADDR_COUNT, 16'h0007);
		wr(`T16W_ADDR_CMP_A, 16'h0005);
		rd(`T16W_ADDR_CMP_A, 16'hffff, 16'h0005);
		meas(1, 5, 1);
		set_mode(16'h0015);
		wr(`T16W_ADDR_CMP_B, 16'hffff);
		rd(`T16W_ADDR_CMP_B, 16'hffff, `T16W_TOP8);
		set_mode(16'h0016);
		wr(`T16W_ADDR_CMP_B, 16'hffff);
		rd(`T16W_ADDR_CMP_B, 16'hffff, `T16W_TOP9);
		set_mode(16'h0017);
		wr(`T16W_ADDR_CMP_B, 16'hffff);
		rd(`T16W_ADDR_CMP_B, 16'hffff, `T16W_TOP10);
		wr(`T16W_ADDR_CMP_B, 16'h0010);
		set_mode(16'h0815);
		meas(1, 17, 239);
		set_mode(16'h001e);
		wr(`T16W_ADDR_CAPTURE, 16'h0064);
		wr(`T16W_ADDR_COUNT, 16'h0032);
		wr(`T16W_ADDR_CAPTURE, 16'h0003);
		wr(`T16W_ADDR_FLAGS, 16'h000f);
		repeat (20) step();
		rd(`T16W_ADDR_FLAGS, 16'h0009, 16'h0000);
		close_out();
	end
endmodule
